//--- ppeb_pkg.sv
package ppeb_pkg;

    // ************************************************
    // timing of one bus cycle, in oscillator periods
    // ************************************************
    localparam int OSC_PER_CYCLE = 6;
    localparam logic [2:0] PH_LAST = 3'(OSC_PER_CYCLE - 1);
    localparam logic [2:0] PH_ALE_END = 3'h1;
    localparam logic [2:0] PH_PFS_BEGIN = 3'h2;
    localparam logic [2:0] PH_STRB_END = 3'h4;
    localparam logic [1:0] SLOT_LAST = 2'h2;

    // ************************************************
    // memory map and reset values
    // ************************************************
    localparam logic [15:0] ROM_LIMIT = 16'h2000;
    localparam logic [7:0] LATCH_RST = 8'hFF;
    localparam logic [1:0] RST_SYNC_RST = 2'h3;
    localparam int NUM_LATCH = 7;

    // ************************************************
    // port numbers for the cpu side
    // ************************************************
    localparam logic [3:0] PORT0 = 4'h0;
    localparam logic [3:0] PORT1 = 4'h1;
    localparam logic [3:0] PORT2 = 4'h2;
    localparam logic [3:0] PORT3 = 4'h3;
    localparam logic [3:0] PORT4 = 4'h4;
    localparam logic [3:0] PORT5 = 4'h5;
    localparam logic [3:0] PORT6 = 4'h6;
    localparam logic [3:0] PORT7 = 4'h7;
    localparam logic [3:0] PORT8 = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_XADDR = 3'b010,
        ST_XSTROBE = 3'b011,
        ST_VERIFY = 3'b100
    } ppeb_state_e;

endpackage : ppeb_pkg

//--- ppeb_tick_if.sv
`timescale 1ns/1ps
interface ppeb_tick_if;
    logic [2:0] phase;
    logic cyc_end;
    logic sysclk;
    modport gen (output phase, output cyc_end, output sysclk);
    modport sink (input phase, input cyc_end, input sysclk);
endinterface : ppeb_tick_if

//--- ppeb_clkgen.sv
`timescale 1ns/1ps
module ppeb_clkgen
    import ppeb_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    ppeb_tick_if.gen tk
);

    typedef struct packed {
        logic div2;
        logic [1:0] slot;
    } ppeb_cg_s;

    ppeb_cg_s cg_reg;
    ppeb_cg_s cg_next;

    always_comb
    begin
        cg_next = cg_reg;
        cg_next.div2 = ~cg_reg.div2;
        if (cg_reg.div2)
        begin
            cg_next.slot = (cg_reg.slot == SLOT_LAST) ? 2'h0 : cg_reg.slot + 2'h1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            cg_reg <= '0;
        end
        else
        begin
            cg_reg <= cg_next;
        end
    end

    // phase runs 0..5, one step per oscillator period
    assign tk.phase = {cg_reg.slot, cg_reg.div2};
    assign tk.cyc_end = (cg_reg.slot == SLOT_LAST) && cg_reg.div2;
    // one third duty, cycle rate; good enough for a board clock
    assign tk.sysclk = (cg_reg.slot == 2'h0);

endmodule : ppeb_clkgen

//--- ppeb_qport.sv
`timescale 1ns/1ps
module ppeb_qport
(
    input wire logic [7:0] i_latch,
    input wire logic [7:0] i_alt_en,
    input wire logic [7:0] i_alt_val,
    input wire logic [7:0] i_strong_en,
    input wire logic [7:0] i_strong_val,
    input wire logic [7:0] i_pin_in,
    output logic [7:0] o_out,
    output logic [7:0] o_oe,
    output logic [7:0] o_pullup,
    output logic [7:0] o_alt_in
);

    genvar b;
    generate
        for (b = 0; b < 8; b++)
        begin : g_bit
            logic val;
            assign val = i_alt_en[b] ? i_alt_val[b] : i_latch[b];
            // without strong drive a one is only a weak pull-up
            assign o_oe[b] = i_strong_en[b] | ~val;
            assign o_out[b] = i_strong_en[b] & i_strong_val[b];
            assign o_pullup[b] = ~i_strong_en[b] & val;
            // alternate inputs idle high while the latch is zero
            assign o_alt_in[b] = i_latch[b] ? i_pin_in[b] : 1'b1;
        end
    endgenerate

endmodule : ppeb_qport

//--- ppeb_top.sv
`timescale 1ns/1ps
module ppeb_top
    import ppeb_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_port_wr,
    input wire logic [3:0] i_port_sel,
    input wire logic [7:0] i_port_wdata,
    input wire logic [3:0] i_port_rd_sel,
    output logic [7:0] o_port_rdata,
    input wire logic i_fetch_req,
    input wire logic [15:0] i_fetch_pc,
    output logic o_fetch_ready,
    output logic o_fetch_valid,
    output logic o_fetch_internal,
    output logic [7:0] o_fetch_data,
    input wire logic i_xdata_req,
    input wire logic i_xdata_wr,
    input wire logic i_xdata_wide,
    input wire logic [15:0] i_xdata_addr,
    input wire logic [7:0] i_xdata_wdata,
    output logic o_xdata_ready,
    output logic o_xdata_done,
    output logic [7:0] o_xdata_rdata,
    input wire logic i_verify_mode,
    input wire logic [7:0] i_verify_code,
    output logic [7:0] o_verify_addr,
    input wire logic [4:0] i_cc_cmp_en,
    input wire logic [4:0] i_cc_cmp_out,
    input wire logic i_sysclk_output_en,
    input wire logic [7:0] i_concurrent_compare_en,
    input wire logic [7:0] i_concurrent_compare_out,
    input wire logic i_serial0_tx_en,
    input wire logic i_serial0_tx,
    input wire logic i_serial1_tx_en,
    input wire logic i_serial1_tx,
    output logic [4:0] o_irq_capture_in,
    output logic o_count2_reload_trigger,
    output logic o_count2_input,
    output logic o_serial0_rx,
    output logic o_ext_irq0,
    output logic o_ext_irq1,
    output logic o_count0_input,
    output logic o_count1_input,
    output logic o_adc_ext_start,
    output logic o_serial1_rx,
    input wire logic i_external_fetch_select_b,
    input wire logic i_osc_monitor_enable,
    output logic o_osc_monitor_enable_pullup,
    output logic o_osc_monitor_active,
    input wire logic i_ext_reset_b,
    input wire logic i_wdt_reset,
    input wire logic i_osc_fail_reset,
    output logic o_reset_out_n,
    output logic o_program_fetch_strobe_n,
    output logic o_address_latch_strobe,
    output logic [11:0] o_analog_in,
    input wire logic [7:0] i_p0_in,
    output logic [7:0] o_p0_out,
    output logic [7:0] o_p0_oe,
    input wire logic [7:0] i_p1_in,
    output logic [7:0] o_p1_out,
    output logic [7:0] o_p1_oe,
    output logic [7:0] o_p1_pullup,
    input wire logic [7:0] i_hi_in,
    output logic [7:0] o_hi_out,
    output logic [7:0] o_hi_oe,
    output logic [7:0] o_hi_pullup,
    input wire logic [7:0] i_p3_in,
    output logic [7:0] o_p3_out,
    output logic [7:0] o_p3_oe,
    output logic [7:0] o_p3_pullup,
    input wire logic [7:0] i_p4_in,
    output logic [7:0] o_p4_out,
    output logic [7:0] o_p4_oe,
    output logic [7:0] o_p4_pullup,
    input wire logic [7:0] i_p5_in,
    output logic [7:0] o_p5_out,
    output logic [7:0] o_p5_oe,
    output logic [7:0] o_p5_pullup,
    input wire logic [7:0] i_p6_in,
    output logic [7:0] o_p6_out,
    output logic [7:0] o_p6_oe,
    output logic [7:0] o_p6_pullup,
    input wire logic [7:0] i_p7_in,
    input wire logic [3:0] i_p8_in
);

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        ppeb_state_e st;
        logic fpend;
        logic [15:0] fpc;
        logic xpend;
        logic xwr;
        logic xwide;
        logic [15:0] xaddr;
        logic [7:0] xwdata;
        logic cur_ext;
        logic cur_wr;
        logic cur_wide;
        logic [15:0] cur_addr;
        logic [7:0] cur_wdata;
        logic [6:0][7:0] lat;
        logic ale;
        logic pfs_n;
        logic [7:0] fdata;
        logic fvalid;
        logic fint;
        logic [7:0] xrdata;
        logic xdone;
        logic [7:0] rdata;
        logic [11:0] analog;
        logic [1:0] rsync;
        logic owd_en;
    } ppeb_top_s;

    localparam ppeb_top_s TOP_RST = '{
        st: ST_IDLE,
        lat: {NUM_LATCH{LATCH_RST}},
        pfs_n: 1'b1,
        rsync: RST_SYNC_RST,
        owd_en: 1'b1,
        default: '0
    };

    ppeb_top_s top_reg;
    ppeb_top_s top_next;

    ppeb_tick_if tk ();

    logic wr_strobe;
    logic rd_strobe;
    logic addr_phase;
    logic ext_bus;
    logic [7:0] p1_strong;
    logic [7:0] hi_strong;
    logic [7:0] p1_ai;
    logic [7:0] p3_ai;
    logic [7:0] p6_ai;
    logic [7:0] p1_aen;
    logic [7:0] p1_aval;
    logic [7:0] p3_aen;
    logic [7:0] p3_aval;
    logic [7:0] p6_aen;
    logic [7:0] p6_aval;

    ppeb_clkgen u_clkgen (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .tk(tk.gen)
    );

    // ************************************************
    // sequencer
    // ************************************************
    always_comb
    begin
        top_next = top_reg;
        top_next.fvalid = 1'b0;
        top_next.xdone = 1'b0;
        if (i_port_wr && (i_port_sel < 4'(NUM_LATCH)))
        begin
            top_next.lat[i_port_sel[2:0]] = i_port_wdata;
        end
        case (i_port_rd_sel)
            PORT0: top_next.rdata = i_p0_in;
            PORT1: top_next.rdata = i_p1_in;
            PORT2: top_next.rdata = i_hi_in;
            PORT3: top_next.rdata = i_p3_in;
            PORT4: top_next.rdata = i_p4_in;
            PORT5: top_next.rdata = i_p5_in;
            PORT6: top_next.rdata = i_p6_in;
            PORT7: top_next.rdata = i_p7_in;
            PORT8: top_next.rdata = {4'h0, i_p8_in};
            default: top_next.rdata = 8'h00;
        endcase
        top_next.analog = {i_p8_in, i_p7_in};
        top_next.rsync = {top_reg.rsync[0], ~i_ext_reset_b | i_wdt_reset | i_osc_fail_reset};
        top_next.owd_en = i_osc_monitor_enable;
        // address strobe, none in data strobe cycle
        top_next.ale = (tk.phase <= PH_ALE_END) && (top_reg.st != ST_XSTROBE) && (top_reg.st != ST_VERIFY);
        // fetch strobe only for external fetch
        top_next.pfs_n = ~((top_reg.st == ST_FETCH) && top_reg.cur_ext && (tk.phase >= PH_PFS_BEGIN));
        if ((top_reg.st == ST_FETCH) && (tk.phase == PH_STRB_END))
        begin
            top_next.fdata = i_p0_in;
            top_next.fint = ~top_reg.cur_ext;
            top_next.fvalid = 1'b1;
        end
        // read data taken while read strobe low
        if ((top_reg.st == ST_XSTROBE) && (tk.phase == PH_STRB_END))
        begin
            if (!top_reg.cur_wr)
            begin
                top_next.xrdata = i_p0_in;
            end
            top_next.xdone = 1'b1;
        end
        if (tk.cyc_end)
        begin
            top_next.st = ST_IDLE;
            if (top_reg.st == ST_XADDR)
            begin
                top_next.st = ST_XSTROBE;
            end
            else if (i_verify_mode)
            begin
                top_next.st = ST_VERIFY;
            end
            else if (top_reg.xpend)
            begin
                top_next.st = ST_XADDR;
                top_next.xpend = 1'b0;
                top_next.cur_wr = top_reg.xwr;
                top_next.cur_wide = top_reg.xwide;
                top_next.cur_addr = top_reg.xaddr;
                top_next.cur_wdata = top_reg.xwdata;
            end
            else if (top_reg.fpend)
            begin
                top_next.st = ST_FETCH;
                top_next.fpend = 1'b0;
                top_next.cur_addr = top_reg.fpc;
                // internal rom only below the limit
                top_next.cur_ext = i_external_fetch_select_b ? (top_reg.fpc >= ROM_LIMIT) : 1'b1;
            end
        end
        // a new request in the take-over cycle is ignored
        if (i_xdata_req && !top_reg.xpend)
        begin
            top_next.xpend = 1'b1;
            top_next.xwr = i_xdata_wr;
            top_next.xwide = i_xdata_wide;
            top_next.xaddr = i_xdata_addr;
            top_next.xwdata = i_xdata_wdata;
        end
        if (i_fetch_req && !top_reg.fpend)
        begin
            top_next.fpend = 1'b1;
            top_next.fpc = i_fetch_pc;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            top_reg <= TOP_RST;
        end
        else
        begin
            top_reg <= top_next;
        end
    end

    // ************************************************
    // pin drive
    // ************************************************
    always_comb
    begin
        ext_bus = ((top_reg.st == ST_FETCH) && top_reg.cur_ext) || (top_reg.st == ST_XADDR);
        addr_phase = ext_bus && (tk.phase <= PH_ALE_END);
        // strobes low in the second data cycle
        wr_strobe = (top_reg.st == ST_XSTROBE) && top_reg.cur_wr && (tk.phase <= PH_STRB_END);
        rd_strobe = (top_reg.st == ST_XSTROBE) && !top_reg.cur_wr && (tk.phase <= PH_STRB_END);
        o_p0_out = 8'h00;
        o_p0_oe = ~top_reg.lat[0];
        if (top_reg.st == ST_VERIFY)
        begin
            // code bytes open drain, pull-ups outside
            o_p0_oe = ~i_verify_code;
        end
        else if (addr_phase)
        begin
            o_p0_out = top_reg.cur_addr[7:0];
            o_p0_oe = 8'hFF;
        end
        else if (ext_bus || (top_reg.st == ST_XSTROBE))
        begin
            o_p0_out = top_reg.cur_wdata;
            o_p0_oe = (top_reg.cur_wr && (top_reg.st != ST_FETCH)) ? 8'hFF : 8'h00;
        end
        // strong upper address for external fetch or wide
        // narrow access leaves the latch on the pins
        hi_strong = 8'h00;
        if (((top_reg.st == ST_FETCH) && top_reg.cur_ext)
            || (((top_reg.st == ST_XADDR) || (top_reg.st == ST_XSTROBE)) && top_reg.cur_wide))
        begin
            hi_strong = 8'hFF;
        end
        p1_strong = 8'h00;
        // compare channels 0..4, clock out on bit 6
        p1_aen = {1'b0, i_sysclk_output_en, 1'b0, i_cc_cmp_en};
        p1_aval = {1'b1, top_reg.lat[1][6] & tk.sysclk, 1'b1, i_cc_cmp_out};
        // data strobes on bits 6 and 7
        // strobes and transmit gated by the latch
        p3_aen = {2'b11, 4'h0, i_serial0_tx_en, 1'b0};
        p3_aval = {top_reg.lat[3][7] & ~rd_strobe, top_reg.lat[3][6] & ~wr_strobe,
                   4'hF, top_reg.lat[3][1] & i_serial0_tx, 1'b1};
        p6_aen = {5'h00, i_serial1_tx_en, 2'b00};
        p6_aval = {5'h1F, top_reg.lat[6][2] & i_serial1_tx, 2'b11};
    end

    ppeb_qport u_p1 (
        .i_latch(top_reg.lat[1]),
        .i_alt_en(p1_aen),
        .i_alt_val(p1_aval),
        .i_strong_en(p1_strong),
        .i_strong_val(8'h00),
        .i_pin_in(i_p1_in),
        .o_out(o_p1_out),
        .o_oe(o_p1_oe),
        .o_pullup(o_p1_pullup),
        .o_alt_in(p1_ai)
    );

    ppeb_qport u_hi (
        .i_latch(top_reg.lat[2]),
        .i_alt_en(8'h00),
        .i_alt_val(8'h00),
        .i_strong_en(hi_strong),
        .i_strong_val(top_reg.cur_addr[15:8]),
        .i_pin_in(i_hi_in),
        .o_out(o_hi_out),
        .o_oe(o_hi_oe),
        .o_pullup(o_hi_pullup),
        .o_alt_in()
    );

    ppeb_qport u_p3 (
        .i_latch(top_reg.lat[3]),
        .i_alt_en(p3_aen),
        .i_alt_val(p3_aval),
        .i_strong_en(8'h00),
        .i_strong_val(8'h00),
        .i_pin_in(i_p3_in),
        .o_out(o_p3_out),
        .o_oe(o_p3_oe),
        .o_pullup(o_p3_pullup),
        .o_alt_in(p3_ai)
    );

    ppeb_qport u_p4 (
        .i_latch(top_reg.lat[4]),
        .i_alt_en(8'h00),
        .i_alt_val(8'h00),
        .i_strong_en(8'h00),
        .i_strong_val(8'h00),
        .i_pin_in(i_p4_in),
        .o_out(o_p4_out),
        .o_oe(o_p4_oe),
        .o_pullup(o_p4_pullup),
        .o_alt_in()
    );

    ppeb_qport u_p5 (
        .i_latch(top_reg.lat[5]),
        .i_alt_en(i_concurrent_compare_en),
        .i_alt_val(i_concurrent_compare_out),
        .i_strong_en(8'h00),
        .i_strong_val(8'h00),
        .i_pin_in(i_p5_in),
        .o_out(o_p5_out),
        .o_oe(o_p5_oe),
        .o_pullup(o_p5_pullup),
        .o_alt_in()
    );

    ppeb_qport u_p6 (
        .i_latch(top_reg.lat[6]),
        .i_alt_en(p6_aen),
        .i_alt_val(p6_aval),
        .i_strong_en(8'h00),
        .i_strong_val(8'h00),
        .i_pin_in(i_p6_in),
        .o_out(o_p6_out),
        .o_oe(o_p6_oe),
        .o_pullup(o_p6_pullup),
        .o_alt_in(p6_ai)
    );

    // ************************************************
    // outputs
    // ************************************************
    // gated inputs from the low port
    assign o_irq_capture_in = p1_ai[4:0];
    assign o_count2_reload_trigger = p1_ai[5];
    assign o_count2_input = p1_ai[7];
    // gated inputs from the third port
    assign o_serial0_rx = p3_ai[0];
    assign o_ext_irq0 = p3_ai[2];
    assign o_ext_irq1 = p3_ai[3];
    assign o_count0_input = p3_ai[4];
    assign o_count1_input = p3_ai[5];
    // gated inputs from the sixth port
    assign o_adc_ext_start = p6_ai[0];
    assign o_serial1_rx = p6_ai[1];
    // verify address seen on the low port
    assign o_verify_addr = i_p1_in;
    assign o_osc_monitor_enable_pullup = 1'b1;
    assign o_osc_monitor_active = top_reg.owd_en;
    assign o_reset_out_n = ~top_reg.rsync[1];
    assign o_program_fetch_strobe_n = top_reg.pfs_n;
    assign o_address_latch_strobe = top_reg.ale;
    assign o_analog_in = top_reg.analog;
    assign o_port_rdata = top_reg.rdata;
    assign o_fetch_ready = ~top_reg.fpend;
    assign o_fetch_valid = top_reg.fvalid;
    assign o_fetch_internal = top_reg.fint;
    assign o_fetch_data = top_reg.fdata;
    assign o_xdata_ready = ~top_reg.xpend;
    assign o_xdata_done = top_reg.xdone;
    assign o_xdata_rdata = top_reg.xrdata;

endmodule : ppeb_top

//--- ppeb_sva.sv
`timescale 1ns/1ps
module ppeb_sva
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_verify_mode,
    input wire logic i_external_fetch_select_b,
    input wire logic i_wdt_reset,
    input wire logic [7:0] i_p1_in,
    input wire logic [7:0] i_p3_in,
    input wire logic [7:0] o_verify_addr,
    input wire logic o_fetch_valid,
    input wire logic o_fetch_internal,
    input wire logic o_program_fetch_strobe_n,
    input wire logic o_address_latch_strobe,
    input wire logic o_count0_input,
    input wire logic o_reset_out_n,
    input wire logic [7:0] o_p0_out,
    input wire logic [7:0] o_p0_oe,
    input wire logic [7:0] o_p4_out,
    input wire logic [7:0] o_p4_oe,
    input wire logic [7:0] o_p4_pullup
);
    // ********
    // pin and strobe relations
    // ********
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    chk_strobes_apart: assert property (!o_program_fetch_strobe_n |-> !o_address_latch_strobe)
        else $error("fetch and address strobes overlap");
    chk_ale_shape: assert property ($rose(o_address_latch_strobe) |=>
        o_address_latch_strobe ##1 (!o_address_latch_strobe)[*4])
        else $error("address strobe width or gap wrong");
    chk_int_fetch_quiet: assert property (o_fetch_valid && o_fetch_internal |->
        o_program_fetch_strobe_n && $past(o_program_fetch_strobe_n))
        else $error("fetch strobe low on internal fetch");
    chk_ext_fetch_strobe: assert property (o_fetch_valid && !o_fetch_internal |->
        !o_program_fetch_strobe_n && !$past(o_program_fetch_strobe_n, 2))
        else $error("fetch strobe missing on external fetch");
    chk_fetch_select: assert property (!i_external_fetch_select_b && o_fetch_valid |-> !o_fetch_internal)
        else $error("internal fetch with select low");
    chk_quasi_weak: assert property (o_p4_pullup == ~(o_p4_oe & ~o_p4_out))
        else $error("weak pull-up mismatch");
    chk_verify_od: assert property (i_verify_mode |->
        (o_p0_oe & o_p0_out) == 8'h00 && o_verify_addr == i_p1_in)
        else $error("verify port drive wrong");
    chk_reset_out: assert property (i_wdt_reset |-> ##[1:3] !o_reset_out_n)
        else $error("reset output not low");
    chk_alt_gate: assert property (!o_count0_input |-> !i_p3_in[4])
        else $error("counter input low without pin");
endmodule : ppeb_sva

bind ppeb_top ppeb_sva ppeb_sva_inst (.*);

//--- ppeb_xmem.sv
`timescale 1ns/1ps
module ppeb_xmem
(
    input wire logic i_clk,
    input wire logic i_vfy,
    input wire logic i_ale,
    input wire logic i_pfs_n,
    input wire logic [7:0] i_ahi,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [1:0] i_strb,
    output logic [7:0] o_pin
);
    logic [7:0] ram [0:65535];
    logic [15:0] adr = 16'h0000;
    logic ale_d = 1'b0;
    logic [7:0] last = 8'h00;
    logic [7:0] mv;
    always @*
    begin
        if (!i_pfs_n)
            mv = adr[15:8] ^ adr[7:0] ^ 8'hC3;
        else if (!i_strb[1])
            mv = ram[adr];
        else
            mv = i_vfy ? 8'hFF : ~last;
    end
    assign o_pin = (i_oe & i_out) | (~i_oe & mv);
    always @(posedge i_clk)
    begin
        ale_d <= i_ale;
        last <= o_pin;
        if (i_ale && !ale_d)
            adr <= {i_ahi, o_pin};
        if (!i_strb[0])
            ram[adr] <= o_pin;
    end
endmodule : ppeb_xmem

//--- test_port_pins_and_external_bus.sv
`timescale 1ns/1ps
module test_port_pins_and_external_bus;
    import ppeb_pkg::*;
    logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_port_wr = 1'b0, i_fetch_req = 1'b0, i_xdata_req = 1'b0;
    logic i_xdata_wr = 1'b0, i_xdata_wide = 1'b0, i_verify_mode = 1'b0, i_sysclk_output_en = 1'b0;
    logic i_serial0_tx_en = 1'b0, i_serial0_tx = 1'b0, i_serial1_tx_en = 1'b0, i_serial1_tx = 1'b0;
    logic i_external_fetch_select_b = 1'b1, i_osc_monitor_enable = 1'b1, i_ext_reset_b = 1'b1;
    logic i_wdt_reset = 1'b0, i_osc_fail_reset = 1'b0, mon_d = 1'b1;
    logic [3:0] i_port_sel = 4'h0, i_port_rd_sel = 4'h0, i_p8_in = 4'h0;
    logic [4:0] i_cc_cmp_en = 5'h00, i_cc_cmp_out = 5'h00, o_irq_capture_in;
    logic [7:0] i_port_wdata = 8'h00, i_xdata_wdata = 8'h00, i_verify_code = 8'h00, i_p7_in = 8'h00;
    logic [7:0] i_concurrent_compare_en = 8'h00, i_concurrent_compare_out = 8'h00;
    logic [15:0] i_fetch_pc = 16'h0000, i_xdata_addr = 16'h0000;
    logic o_fetch_ready, o_fetch_valid, o_fetch_internal, o_xdata_ready, o_xdata_done, o_count2_input;
    logic o_count2_reload_trigger, o_serial0_rx, o_ext_irq0, o_ext_irq1, o_count0_input, o_count1_input;
    logic o_adc_ext_start, o_serial1_rx, o_osc_monitor_enable_pullup, o_osc_monitor_active, o_reset_out_n;
    logic o_program_fetch_strobe_n, o_address_latch_strobe;
    logic [11:0] o_analog_in;
    logic [7:0] o_port_rdata, o_fetch_data, o_xdata_rdata, o_verify_addr, o_p0_out, o_p0_oe, i_p0_in;
    logic [7:0] o_p1_out, o_p1_oe, o_p1_pullup, o_hi_out, o_hi_oe, o_hi_pullup, o_p3_out, o_p3_oe, o_p3_pullup;
    logic [7:0] o_p4_out, o_p4_oe, o_p4_pullup, o_p5_out, o_p5_oe, o_p5_pullup, o_p6_out, o_p6_oe, o_p6_pullup;
    logic [7:0] i_p1_in, i_hi_in, i_p3_in, i_p4_in, i_p5_in, i_p6_in;
    logic [7:0] r = 8'h31, e1 = 8'hFF, e3 = 8'hFF, e4 = 8'hFF;
    logic [15:0] pcs [3] = '{16'h0000, 16'h1FFF, 16'h2000};
    logic [8:0] qf[$], qx[$], d;
    int err_total = 0, n_checks = 0;

    ppeb_top ppeb_top_inst (.*);
    ppeb_xmem ppeb_xmem_inst (.i_clk(i_ref_clk), .i_vfy(i_verify_mode), .i_ale(o_address_latch_strobe),
        .i_pfs_n(o_program_fetch_strobe_n), .i_ahi(i_hi_in), .i_out(o_p0_out), .i_oe(o_p0_oe),
        .i_strb(i_p3_in[7:6]), .o_pin(i_p0_in));

    // ********
    // board wiring: weak pins lose to the outside level
    // ********
    assign i_p1_in = (o_p1_oe & o_p1_out) | (~o_p1_oe & e1);
    assign i_hi_in = (o_hi_oe & o_hi_out) | ~o_hi_oe;
    assign i_p3_in = (o_p3_oe & o_p3_out) | (~o_p3_oe & e3);
    assign i_p4_in = (o_p4_oe & o_p4_out) | (~o_p4_oe & e4);
    assign i_p5_in = (o_p5_oe & o_p5_out) | (~o_p5_oe & e4);
    assign i_p6_in = (o_p6_oe & o_p6_out) | (~o_p6_oe & ~e4);

    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nx

    task automatic cmp_bus(input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (e !== g)
        begin
            err_total++;
            $display("[ERR] %0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp_bus

    task automatic cmp_port(input logic [7:0] e, input logic [7:0] g);
        cmp_bus({1'b0, e}, {1'b0, g});
    endtask : cmp_port

    task automatic finish_test;
        // an answer never seen counts as lost
        if (qf.size() + qx.size() != 0)
            err_total++;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task automatic wr(input logic [3:0] p, input logic [7:0] v);
        @(posedge i_ref_clk);
        i_port_wr <= 1'b1;
        i_port_sel <= p;
        i_port_wdata <= v;
        @(posedge i_ref_clk);
        i_port_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] p, input logic [7:0] v);
        @(posedge i_ref_clk);
        i_port_rd_sel <= p;
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        cmp_port(v, o_port_rdata);
    endtask : rd

    task automatic fetch(input logic [15:0] pc);
        @(negedge i_ref_clk);
        for (int n = 0; n < 40 && o_fetch_ready !== 1'b1; n++)
            @(negedge i_ref_clk);
        @(posedge i_ref_clk);
        i_fetch_req <= 1'b1;
        i_fetch_pc <= pc;
        qf.push_back(i_external_fetch_select_b && pc < ROM_LIMIT ? 9'h100 : {1'b0, pc[15:8] ^ pc[7:0] ^ 8'hC3});
        @(posedge i_ref_clk);
        i_fetch_req <= 1'b0;
    endtask : fetch

    task automatic xd(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] v);
        @(negedge i_ref_clk);
        for (int n = 0; n < 40 && o_xdata_ready !== 1'b1; n++)
            @(negedge i_ref_clk);
        @(posedge i_ref_clk);
        i_xdata_req <= 1'b1;
        i_xdata_wr <= w;
        i_xdata_wide <= wd;
        i_xdata_addr <= a;
        i_xdata_wdata <= v;
        qx.push_back({w, v});
        @(posedge i_ref_clk);
        i_xdata_req <= 1'b0;
    endtask : xd

    task automatic drain;
        for (int n = 0; n < 60 && qf.size() + qx.size() != 0; n++)
            @(negedge i_ref_clk);
    endtask : drain

    // clock source drives the oscillator input
    initial
    begin
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk)
    begin
        r <= nx(r);
        {i_serial0_tx, i_serial1_tx, i_serial0_tx_en, i_serial1_tx_en, i_osc_monitor_enable} <= r[4:0];
        mon_d <= i_osc_monitor_enable;
        i_concurrent_compare_en <= r;
        i_concurrent_compare_out <= ~r;
        i_cc_cmp_out <= r[7:3];
        i_p7_in <= r;
        i_p8_in <= r[3:0];
        e3 <= {2'b11, r[5:0]};
        e4 <= r ^ 8'h5C;
    end

    always @(negedge i_ref_clk)
    begin
        if (o_fetch_valid === 1'b1)
            cmp_bus(qf.pop_front(), {o_fetch_internal, o_fetch_data & {8{~o_fetch_internal}}});
        if (o_xdata_done === 1'b1)
        begin
            d = qx.pop_front();
            cmp_bus(d, {d[8], d[8] ? ppeb_xmem_inst.ram[ppeb_xmem_inst.adr] : o_xdata_rdata});
        end
        if (o_reset_out_n === 1'b1)
            cmp_port({7'h00, mon_d}, {7'h00, o_osc_monitor_active});
    end

    initial
    begin
        repeat (10) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        repeat (4) @(negedge i_ref_clk);
        cmp_port(8'h01, {7'h00, o_reset_out_n});
        @(posedge i_ref_clk);
        e1 <= 8'hA5;
        rd(PORT1, 8'hA5);
        wr(PORT1, 8'h0F);
        rd(PORT1, 8'h05);
        cmp_port(8'h15, {3'h0, o_irq_capture_in});
        wr(PORT1, 8'hFF);
        rd(4'h9, 8'h00);
        wr(PORT4, r);
        for (int s = 0; s < 2; s++)
        begin
            @(posedge i_ref_clk);
            i_external_fetch_select_b <= s[0];
            foreach (pcs[k])
                fetch(pcs[k]);
            drain();
        end
        xd(1'b1, 1'b1, 16'h1234, 8'hA7);
        xd(1'b0, 1'b1, 16'h1234, 8'hA7);
        wr(PORT2, 8'h3C);
        xd(1'b1, 1'b0, 16'hFF77, 8'h3E);
        xd(1'b0, 1'b1, 16'h3C77, 8'h3E);
        xd(1'b0, 1'b0, 16'h0077, 8'h3E);
        drain();
        @(posedge i_ref_clk);
        i_verify_mode <= 1'b1;
        i_verify_code <= 8'h96;
        // verify only takes over at the next bus cycle boundary
        repeat (6) @(posedge i_ref_clk);
        rd(PORT0, 8'h96);
        @(posedge i_ref_clk);
        i_verify_mode <= 1'b0;
        i_wdt_reset <= 1'b1;
        @(posedge i_ref_clk);
        i_wdt_reset <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        finish_test();
    end

    // about 160 cycles expected; generous limit
    initial
    begin
        #3000000;
        err_total++;
        finish_test();
    end
endmodule : test_port_pins_and_external_bus
